// *** hdl/lcdt_pkg.sv ***
// ****************************************************************
// Shared constants for the LCD timing core
// ****************************************************************
package lcdt_pkg;

  localparam int NUM_SEG          = 40;
  localparam int NUM_ROW          = 4;
  localparam int BYTE_BITS        = 8;
  localparam int PEND_BITS        = 16;

  // Base clock and internal oscillator period
  localparam int CLK_PERIOD_NS    = 8;
  localparam int OSC_PERIOD_NS    = 5000;
  localparam int OSC_HALF_CYC     = OSC_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // Working clock to frame divisors
  localparam int FRAME_DIV_NORMAL = 2880;
  localparam int FRAME_DIV_SAVE   = 480;

  typedef enum logic [1:0] {
    LCDT_STATIC = 2'h0,
    LCDT_MUX2   = 2'h1,
    LCDT_MUX3   = 2'h2,
    LCDT_MUX4   = 2'h3
  } lcdt_mode_t;

  localparam lcdt_mode_t RESET_MODE = LCDT_MUX4;
  localparam logic RESET_SAVE       = 1'b0;

  typedef enum logic [1:0] {
    LCDT_XF_COPY = 2'h1,
    LCDT_XF_WAIT = 2'h2
  } lcdt_xfer_t;

endpackage : lcdt_pkg

// *** hdl/lcdt_frame_div.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Frame divider: slots and polarity halves per frame
// ****************************************************************
module lcdt_frame_div (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       tick_i,
  input  wire logic       restart_i,
  input  wire logic       save_i,
  input  wire logic [2:0] rows_i,
  output logic      [1:0] slot_o,
  output logic            pol_o,
  output logic            frame_o
);

  logic [11:0] base;
  logic [11:0] phase_len;
  logic [11:0] cnt;

  always_comb begin
    base = save_i ? 12'(lcdt_pkg::FRAME_DIV_SAVE)
                  : 12'(lcdt_pkg::FRAME_DIV_NORMAL);
    case (rows_i)
      3'h1:    phase_len = base >> 1;
      3'h2:    phase_len = base >> 2;
      3'h3:    phase_len = base / 12'h006;
      default: phase_len = base >> 3;
    endcase
  end

  // Two halves per slot, one slot per active row
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt     <= 12'h000;
      slot_o  <= 2'h0;
      pol_o   <= 1'b0;
      frame_o <= 1'b0;
    end else if (ce_i) begin
      frame_o <= 1'b0;
      if (restart_i) begin
        cnt     <= 12'h000;
        slot_o  <= 2'h0;
        pol_o   <= 1'b0;
        frame_o <= 1'b1;
      end else if (tick_i) begin
        if (cnt >= phase_len - 12'h001) begin
          cnt <= 12'h000;
          if (pol_o) begin
            pol_o <= 1'b0;
            if ({1'b0, slot_o} >= rows_i - 3'h1) begin
              slot_o  <= 2'h0;
              frame_o <= 1'b1;
            end else begin
              slot_o <= slot_o + 2'h1;
            end
          end else begin
            pol_o <= 1'b1;
          end
        end else begin
          cnt <= cnt + 12'h001;
        end
      end
    end
  end

endmodule : lcdt_frame_div

// *** hdl/lcdt_timing.sv ***
`timescale 1ns/1ps
// Behaviour
// - Source pin low: internal oscillator, driven out.
// - Source pin high: clock pin is input.
// - Frame is clock over 2880 or 480.
// - Internal clock: power mode from mode-set.
// - Hold I2C clock low while 8 or more bits are queued.
// - Shift register refills display register in background.
// - Shared sync line aligns cascaded frames.
// - Forty segments from display register and phase.
// - 1:4 mode: four distinct backplanes.
// - 1:3 mode: backplane 3 copies backplane 1.
// - 1:2 mode: 2 copies 0, 3 copies 1.
// - Static mode: all backplanes identical.
// - Display memory is 40 by 4 bits.
// - Stored one lights element, zero darkens.
// - Rows to backplanes, columns to segments.
// - Display bits queued, then stored one per working clock tick.
// - Bits per column follow drive mode.
// - Reset: 1:4 mode, pointers cleared, segment and backplane outputs high.
module lcdt_timing #(
  parameter int NSEG = lcdt_pkg::NUM_SEG
) (
  input  wire logic            CLK_I,
  input  wire logic            SYS_RST_I,
  input  wire logic            CE_I,
  input  wire logic            OSC_SEL_I,
  input  wire logic            EXT_CLK_I,
  input  wire logic            MODE_SET_I,
  input  wire logic [1:0]      MODE_I,
  input  wire logic            POWER_SAVE_I,
  input  wire logic            PTR_LOAD_I,
  input  wire logic [5:0]      PTR_I,
  input  wire logic            BIT_VALID_I,
  input  wire logic            BIT_I,
  input  wire logic            SYNC_I,
  output logic                 SYNC_O,
  output logic                 SYNC_OE_O,
  output logic                 CLK_OUT_O,
  output logic                 CLK_OE_O,
  output logic                 SCL_HOLD_O,
  output logic                 FRAME_RATE_O,
  output logic [NSEG-1:0]      SEGMENT_OUTPUTS_O,
  output logic                 BACKPLANE_OUT_0_O,
  output logic                 BACKPLANE_OUT_1_O,
  output logic                 BACKPLANE_OUT_2_O,
  output logic                 BACKPLANE_OUT_3_O
);

  localparam int NROW = lcdt_pkg::NUM_ROW;
  localparam int PB   = lcdt_pkg::PEND_BITS;

  // ****************************************************************
  // Working clock selection
  // ****************************************************************
  logic [9:0]  osc_cnt;
  logic        osc_tog;
  logic        osc_tick;
  logic        ext_q;
  logic        wtick;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      osc_cnt  <= 10'h000;
      osc_tog  <= 1'b0;
      osc_tick <= 1'b0;
    end else if (CE_I) begin
      osc_tick <= 1'b0;
      if (osc_cnt >= 10'(lcdt_pkg::OSC_HALF_CYC - 1)) begin
        osc_cnt  <= 10'h000;
        osc_tog  <= ~osc_tog;
        osc_tick <= ~osc_tog;
      end else begin
        osc_cnt <= osc_cnt + 10'h001;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      ext_q     <= 1'b1;
      CLK_OUT_O <= 1'b0;
      CLK_OE_O  <= 1'b0;
    end else if (CE_I) begin
      ext_q     <= EXT_CLK_I;
      CLK_OUT_O <= osc_tog;
      CLK_OE_O  <= ~OSC_SEL_I;
    end
  end

  // Outputs freeze if the external clock stops
  assign wtick = OSC_SEL_I ? (EXT_CLK_I & ~ext_q)
                           : osc_tick;

  // ****************************************************************
  // Drive mode and power mode
  // ****************************************************************
  lcdt_pkg::lcdt_mode_t mode;
  logic                 save;
  logic [2:0]           rows;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      mode <= lcdt_pkg::RESET_MODE;
      save <= lcdt_pkg::RESET_SAVE;
    end else if (CE_I && MODE_SET_I) begin
      mode <= lcdt_pkg::lcdt_mode_t'(MODE_I);
      save <= POWER_SAVE_I;
    end
  end

  assign rows = {1'b0, mode} + 3'h1;

  // ****************************************************************
  // Incoming bit queue and clock stretch
  // ****************************************************************
  logic [PB-1:0] pend;
  logic [PB-1:0] next_pend;
  logic [4:0]    pcnt;
  logic [4:0]    next_pcnt;
  logic          pop;
  logic          push;

  assign pop  = wtick && (pcnt != 5'h00);
  assign push = BIT_VALID_I && (pcnt != 5'(PB));

  always_comb begin
    next_pend = pend;
    next_pcnt = pcnt;
    if (pop) begin
      next_pend = {1'b0, pend[PB-1:1]};
      next_pcnt = pcnt - 5'h01;
    end
    if (push) begin
      next_pend[next_pcnt[3:0]] = BIT_I;
      next_pcnt = next_pcnt + 5'h01;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      pend       <= '0;
      pcnt       <= 5'h00;
      SCL_HOLD_O <= 1'b0;
    end else if (CE_I) begin
      pend       <= next_pend;
      pcnt       <= next_pcnt;
      SCL_HOLD_O <= next_pcnt >= 5'(lcdt_pkg::BYTE_BITS);
    end
  end

  // ****************************************************************
  // Display memory and write pointer
  // ****************************************************************
  logic [NSEG-1:0] ram [NROW];
  logic [5:0]      wcol;
  logic [1:0]      wrow;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      wcol <= 6'h00;
      wrow <= 2'h0;
    end else if (CE_I) begin
      if (PTR_LOAD_I) begin
        wcol <= PTR_I;
        wrow <= 2'h0;
      end else if (pop) begin
        if ({1'b0, wrow} >= rows - 3'h1) begin
          wrow <= 2'h0;
          wcol <= (wcol >= 6'(NSEG - 1)) ? 6'h00 : wcol + 6'h01;
        end else begin
          wrow <= wrow + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      for (int r = 0; r < NROW; r++) begin
        ram[r] <= '0;
      end
    end else if (CE_I && pop && !PTR_LOAD_I) begin
      ram[wrow][wcol] <= pend[0];
    end
  end

  // ****************************************************************
  // Frame timing and cascade sync
  // ****************************************************************
  logic [1:0] slot;
  logic       pol;
  logic       frame;
  logic       sync_q;
  logic       restart;

  // Another device pulled the line low first
  assign restart = sync_q && !SYNC_I && !SYNC_OE_O;

  lcdt_frame_div u_frame (
    .clk_i     (CLK_I),
    .rst_i     (SYS_RST_I),
    .ce_i      (CE_I),
    .tick_i    (wtick),
    .restart_i (restart),
    .save_i    (save),
    .rows_i    (rows),
    .slot_o    (slot),
    .pol_o     (pol),
    .frame_o   (frame)
  );

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sync_q       <= 1'b1;
      SYNC_O       <= 1'b0;
      SYNC_OE_O    <= 1'b0;
      FRAME_RATE_O <= 1'b0;
    end else if (CE_I) begin
      sync_q       <= SYNC_I;
      SYNC_O       <= 1'b0;
      SYNC_OE_O    <= (slot == 2'h0) && !pol;
      FRAME_RATE_O <= frame;
    end
  end

  // ****************************************************************
  // Shift register into display register
  // ****************************************************************
  lcdt_pkg::lcdt_xfer_t xstate;
  logic [5:0]           xcol;
  logic [NSEG-1:0]      shadow [NROW];
  logic [NSEG-1:0]      disp   [NROW];

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      xstate <= lcdt_pkg::LCDT_XF_COPY;
      xcol   <= 6'h00;
    end else if (CE_I) begin
      case (xstate)
        lcdt_pkg::LCDT_XF_COPY: begin
          if (wtick) begin
            if (xcol >= 6'(NSEG - 1)) begin
              xstate <= lcdt_pkg::LCDT_XF_WAIT;
            end else begin
              xcol <= xcol + 6'h01;
            end
          end
        end
        lcdt_pkg::LCDT_XF_WAIT: begin
          if (frame) begin
            xstate <= lcdt_pkg::LCDT_XF_COPY;
            xcol   <= 6'h00;
          end
        end
        default: begin
          xstate <= lcdt_pkg::LCDT_XF_COPY;
          xcol   <= 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      for (int r = 0; r < NROW; r++) begin
        shadow[r] <= '0;
        disp[r]   <= '0;
      end
    end else if (CE_I) begin
      for (int r = 0; r < NROW; r++) begin
        if (xstate == lcdt_pkg::LCDT_XF_COPY && wtick) begin
          shadow[r][xcol] <= ram[r][xcol];
        end
        if (xstate == lcdt_pkg::LCDT_XF_WAIT && frame) begin
          disp[r] <= shadow[r];
        end
      end
    end
  end

  // ****************************************************************
  // Backplane and segment drive
  // ****************************************************************
  logic [NROW-1:0] bp_raw;
  logic [NROW-1:0] bp_map;
  logic [NSEG-1:0] seg_next;
  logic            blank;

  // Selected row sits opposite the polarity
  always_comb begin
    for (int r = 0; r < NROW; r++) begin
      bp_raw[r] = (slot == 2'(r)) ? ~pol : pol;
    end
  end

  always_comb begin
    case (mode)
      lcdt_pkg::LCDT_STATIC:
        bp_map = {NROW{bp_raw[0]}};
      lcdt_pkg::LCDT_MUX2:
        bp_map = {bp_raw[1], bp_raw[0],
                  bp_raw[1], bp_raw[0]};
      lcdt_pkg::LCDT_MUX3:
        bp_map = {bp_raw[1], bp_raw[2],
                  bp_raw[1], bp_raw[0]};
      lcdt_pkg::LCDT_MUX4:
        bp_map = bp_raw;
      default:
        bp_map = bp_raw;
    endcase
  end

  // On element drives against its backplane
  for (genvar c = 0; c < NSEG; c++) begin : g_seg
    assign seg_next[c] = disp[slot][c] ? pol : ~pol;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      blank <= 1'b1;
    end else if (CE_I && frame) begin
      blank <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      SEGMENT_OUTPUTS_O <= '1;
      BACKPLANE_OUT_0_O <= 1'b1;
      BACKPLANE_OUT_1_O <= 1'b1;
      BACKPLANE_OUT_2_O <= 1'b1;
      BACKPLANE_OUT_3_O <= 1'b1;
    end else if (CE_I) begin
      if (blank) begin
        SEGMENT_OUTPUTS_O <= '1;
        BACKPLANE_OUT_0_O <= 1'b1;
        BACKPLANE_OUT_1_O <= 1'b1;
        BACKPLANE_OUT_2_O <= 1'b1;
        BACKPLANE_OUT_3_O <= 1'b1;
      end else begin
        SEGMENT_OUTPUTS_O <= seg_next;
        BACKPLANE_OUT_0_O <= bp_map[0];
        BACKPLANE_OUT_1_O <= bp_map[1];
        BACKPLANE_OUT_2_O <= bp_map[2];
        BACKPLANE_OUT_3_O <= bp_map[3];
      end
    end
  end

endmodule : lcdt_timing

// *** verification/lcdt_timing_sva.sv ***
`timescale 1ns/1ps
// ********************
// LCD timing checker
// ********************
module lcdt_timing_sva #(
  parameter int NSEG = lcdt_pkg::NUM_SEG
) (
  input logic            CLK_I,
  input logic            SYS_RST_I,
  input logic            CE_I,
  input logic            OSC_SEL_I,
  input logic            EXT_CLK_I,
  input logic            MODE_SET_I,
  input logic [1:0]      MODE_I,
  input logic            BIT_VALID_I,
  input logic            SYNC_O,
  input logic            SYNC_OE_O,
  input logic            CLK_OE_O,
  input logic            SCL_HOLD_O,
  input logic            FRAME_RATE_O,
  input logic [NSEG-1:0] SEGMENT_OUTPUTS_O,
  input logic            BACKPLANE_OUT_0_O,
  input logic            BACKPLANE_OUT_1_O,
  input logic            BACKPLANE_OUT_2_O,
  input logic            BACKPLANE_OUT_3_O
);
  logic [1:0] md;
  logic [1:0] stab;
  logic [3:0] bp;

  assign bp = {BACKPLANE_OUT_3_O, BACKPLANE_OUT_2_O, BACKPLANE_OUT_1_O,
               BACKPLANE_OUT_0_O};

  // Mirror of drive mode and cycles since it was last set
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I)
      md <= lcdt_pkg::RESET_MODE;
    else if (CE_I && MODE_SET_I)
      md <= MODE_I;
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || (CE_I && MODE_SET_I))
      stab <= 2'h0;
    else if (stab != 2'h3)
      stab <= stab + 2'h1;
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  reset_high_a: assert property (
    $fell(SYS_RST_I) |-> &{SEGMENT_OUTPUTS_O, bp})
    else $error("outputs not high after reset");
  clk_drive_a: assert property (
    !$past(SYS_RST_I) && $past(CE_I) |-> CLK_OE_O == !$past(OSC_SEL_I))
    else $error("clock pin direction wrong");
  static_bp_a: assert property (
    stab == 2'h3 && md == lcdt_pkg::LCDT_STATIC |-> bp == {4{bp[0]}})
    else $error("static backplanes differ");
  mux2_bp_a: assert property (
    stab == 2'h3 && md == lcdt_pkg::LCDT_MUX2 |-> bp[3:2] == bp[1:0])
    else $error("duplex backplane copies wrong");
  mux3_bp_a: assert property (
    stab == 2'h3 && md == lcdt_pkg::LCDT_MUX3 |-> bp[3] == bp[1])
    else $error("triplex backplane copy wrong");
  hold_cause_a: assert property (
    $rose(SCL_HOLD_O) |-> $past(BIT_VALID_I))
    else $error("stretch without a bit");
  hold_drain_a: assert property (
    $fell(SCL_HOLD_O) && OSC_SEL_I |-> $past(EXT_CLK_I) || $past(EXT_CLK_I, 2))
    else $error("stretch released off a tick");
  frame_pulse_a: assert property (
    FRAME_RATE_O |=> !FRAME_RATE_O)
    else $error("frame pulse too long");
  sync_low_a: assert property (
    SYNC_OE_O |-> SYNC_O == 1'b0)
    else $error("sync driven high");
  sync_start_a: assert property (
    FRAME_RATE_O |-> ##[0:2] SYNC_OE_O)
    else $error("sync not driven at frame start");

  cover property (md == lcdt_pkg::LCDT_MUX4 && FRAME_RATE_O);
  cover property ($rose(SCL_HOLD_O));
  cover property (stab == 2'h3 && md == lcdt_pkg::LCDT_STATIC);
endmodule : lcdt_timing_sva

bind lcdt_timing lcdt_timing_sva #(.NSEG(NSEG)) u_sva (
  .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .CE_I(CE_I),
  .OSC_SEL_I(OSC_SEL_I), .EXT_CLK_I(EXT_CLK_I), .MODE_SET_I(MODE_SET_I),
  .MODE_I(MODE_I), .BIT_VALID_I(BIT_VALID_I), .SYNC_O(SYNC_O),
  .SYNC_OE_O(SYNC_OE_O), .CLK_OE_O(CLK_OE_O), .SCL_HOLD_O(SCL_HOLD_O),
  .FRAME_RATE_O(FRAME_RATE_O), .SEGMENT_OUTPUTS_O(SEGMENT_OUTPUTS_O),
  .BACKPLANE_OUT_0_O(BACKPLANE_OUT_0_O),
  .BACKPLANE_OUT_1_O(BACKPLANE_OUT_1_O),
  .BACKPLANE_OUT_2_O(BACKPLANE_OUT_2_O),
  .BACKPLANE_OUT_3_O(BACKPLANE_OUT_3_O));

// *** verification/lcdt_host_model.sv ***
`timescale 1ns/1ps
// ********************
// Host and clock source
// ********************
module lcdt_host_model (
  input  logic clk_i,
  input  logic hold_i,
  output logic ext_clk_o,
  output logic bit_valid_o,
  output logic bit_o
);
  logic [1:0] ph = 2'h0;

  initial begin
    bit_valid_o = 1'b0;
    bit_o = 1'b0;
  end

  // Free-running clock of 4 cycles, never stopped
  always @(negedge clk_i) begin
    ph <= ph + 2'h1;
  end
  assign ext_clk_o = ph[1];

  // One bit a cycle, MSB first, pausing while stretched
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(negedge clk_i);
      while (hold_i) begin
        bit_valid_o = 1'b0;
        @(negedge clk_i);
      end
      bit_valid_o = 1'b1;
      bit_o = b[i];
    end
    @(negedge clk_i);
    bit_valid_o = 1'b0;
    bit_o = ~bit_o;
  endtask : send
endmodule : lcdt_host_model

// *** verification/lcdt_timing_tb_top.sv ***
`timescale 1ns/1ps
// ********************
// LCD timing bench
// ********************
module lcdt_timing_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        osc_sel = 1'b0;
  logic        mset = 1'b0;
  logic [1:0]  mode = 2'h3;
  logic        psave = 1'b0;
  logic        pload = 1'b0;
  logic [5:0]  ptr = 6'h0;
  logic        sync_drv = 1'b1;
  logic        ext_clk, bvalid, bitv, sync_oe, sync_o;
  logic        clk_out, clk_oe, hold, frame;
  logic [39:0] seg;
  logic [3:0]  bp;
  wire         sync_w = sync_drv & ~(sync_oe & ~sync_o);
  int          fail_count = 0;
  int          num_checks = 0;

  always #4 clk = ~clk;

  lcdt_timing DUT (.CLK_I(clk), .SYS_RST_I(rst), .CE_I(1'b1),
    .OSC_SEL_I(osc_sel), .EXT_CLK_I(ext_clk), .MODE_SET_I(mset),
    .MODE_I(mode), .POWER_SAVE_I(psave), .PTR_LOAD_I(pload), .PTR_I(ptr),
    .BIT_VALID_I(bvalid), .BIT_I(bitv), .SYNC_I(sync_w), .SYNC_O(sync_o),
    .SYNC_OE_O(sync_oe), .CLK_OUT_O(clk_out), .CLK_OE_O(clk_oe),
    .SCL_HOLD_O(hold), .FRAME_RATE_O(frame), .SEGMENT_OUTPUTS_O(seg),
    .BACKPLANE_OUT_0_O(bp[0]), .BACKPLANE_OUT_1_O(bp[1]),
    .BACKPLANE_OUT_2_O(bp[2]), .BACKPLANE_OUT_3_O(bp[3]));

  lcdt_host_model host (.clk_i(clk), .hold_i(hold), .ext_clk_o(ext_clk),
    .bit_valid_o(bvalid), .bit_o(bitv));

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic end_sim;
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic wait_frame(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (frame !== 1'b1 && n < 20000);
    if (frame !== 1'b1) fail_count++;
  endtask : wait_frame

  task automatic set_mode(input logic [1:0] m, input logic s);
    @(negedge clk);
    mode = m;
    psave = s;
    mset = 1'b1;
    @(negedge clk);
    mset = 1'b0;
  endtask : set_mode

  // Row whose backplane level differs from the rest
  function automatic int sel_row(input logic [3:0] v);
    sel_row = 0;
    for (int r = 0; r < 4; r++)
      if ((v ^ {4{v[(r + 1) % 4]}}) == (4'h1 << r)) sel_row = r;
  endfunction : sel_row

  task automatic t_osc;
    int n;
    logic v;
    check(seg, '1);
    check(40'(bp), 40'hf);
    check(40'(clk_oe), 40'h1);
    for (int k = 0; k < 2; k++) begin
      v = clk_out;
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (clk_out === v && n < 1000);
    end
    check(40'(n), 40'(lcdt_pkg::OSC_HALF_CYC));
    osc_sel = 1'b1;
    repeat (2) @(negedge clk);
    check(40'(clk_oe), 40'h0);
  endtask : t_osc

  task automatic t_frame;
    int n;
    set_mode(2'h3, 1'b1);
    repeat (2) wait_frame(n);
    check(40'(n), 40'(4 * lcdt_pkg::FRAME_DIV_SAVE));
    set_mode(2'h3, 1'b0);
    repeat (2) wait_frame(n);
    check(40'(n), 40'(4 * lcdt_pkg::FRAME_DIV_NORMAL));
  endtask : t_frame

  task automatic t_data;
    int n;
    int r;
    logic seen;
    logic [3:0] m;
    logic [19:0] w;
    w = 20'ha53c0;
    seen = 1'b0;
    m = 4'h0;
    set_mode(2'h3, 1'b1);
    @(negedge clk);
    pload = 1'b1;
    @(negedge clk);
    pload = 1'b0;
    fork
      begin
        host.send(w[19:12]);
        host.send(w[11:4]);
      end
      repeat (40) begin
        @(negedge clk);
        seen |= hold;
      end
    join
    check(40'(seen), 40'h1);
    repeat (3) wait_frame(n);
    repeat (48) begin
      repeat (40) @(negedge clk);
      r = sel_row(bp);
      m[r] = 1'b1;
      for (int c = 0; c < 5; c++)
        check(40'(seg[c]), 40'(bp[r] ^ w[19 - 4 * c - r]));
    end
    check(40'(m), 40'hf);
  endtask : t_data

  task automatic t_static;
    int n;
    set_mode(2'h0, 1'b1);
    @(negedge clk);
    ptr = 6'h4;
    pload = 1'b1;
    @(negedge clk);
    pload = 1'b0;
    host.send(8'hc0);
    repeat (3) wait_frame(n);
    repeat (24) begin
      repeat (80) @(negedge clk);
      check(40'(seg[11:0]), 40'({12{bp[0]}} ^ 12'h039));
    end
  endtask : t_static

  task automatic t_modes;
    for (int m = 1; m < 3; m++) begin
      set_mode(2'(m), 1'b1);
      repeat (300) @(negedge clk);
      check(40'(bp), 40'({bp[1], m == 1 ? bp[0] : bp[2], bp[1:0]}));
    end
  endtask : t_modes

  task automatic t_sync;
    int n;
    set_mode(2'h3, 1'b1);
    wait_frame(n);
    repeat (500) @(negedge clk);
    sync_drv = 1'b0;
    wait_frame(n);
    sync_drv = 1'b1;
    check(40'(n < 5), 40'h1);
  endtask : t_sync

  // Second reset in mid-run: outputs return to the high level
  task automatic t_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(seg, '1);
    check(40'(bp), 40'hf);
    repeat (2) @(negedge clk);
    check(seg, '1);
    check(40'(bp), 40'hf);
  endtask : t_reset

  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    end_sim();
  end

  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_osc();
    t_frame();
    t_data();
    t_static();
    t_modes();
    t_sync();
    t_reset();
    end_sim();
  end
endmodule : lcdt_timing_tb_top
